// file: hw/rh_status_pkg.sv
// Constants, field positions and types for the root hub global status block.
// Assumes a 32-bit AXI4-Lite register bus and four downstream ports.
`default_nettype none
package rh_status_pkg;
    localparam int ADDR_W = 8;
    localparam int NPORTS = 4;
    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFF_PWR_MASK = 8'h4C;
    localparam logic [7:0] OFF_HUB_STATUS = 8'h50;
    localparam logic [7:0] OFF_PWR_CTRL = 8'h60;
    localparam logic [7:0] OFF_HUB_CTRL = 8'h64;
    localparam logic [7:0] OFF_INT_STATUS = 8'h68;
    localparam logic [7:0] OFF_INT_MASK = 8'h6C;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int B_CLR_WAKE = 31;
    localparam int B_OC_CHANGE = 17;
    localparam int B_SET_PWR = 16;
    localparam int B_WAKE = 15;
    localparam int B_OC = 1;
    localparam int B_CLR_PWR = 0;
    localparam int B_MASK_LO = 17;
    localparam int B_PP_SET_LO = 1;
    localparam int B_PP_CLR_LO = 9;
    localparam int B_PER_PORT_PWR = 0;
    localparam int B_PER_PORT_OC = 1;
    localparam int B_SUSPEND_CMD = 2;
    localparam int B_OPER_CMD = 3;
    localparam int B_STATE_LO = 4;
    localparam int I_OC = 0;
    localparam int I_RESUME = 1;
    // ************************************************************
    // Reset values and responses
    // ************************************************************
    localparam logic [3:0] RST_PORTS = 4'h0;
    localparam logic [1:0] RST_INT = 2'h0;
    localparam logic [2:0] RST_SYNC = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        bus_operational = 2'h0,
        bus_suspended_state = 2'h1,
        bus_resuming_state = 2'h3
    } bus_state_t;
endpackage
`default_nettype wire

// file: hw/root_hub_global_status.sv
// Root hub global status/control register bank behind an AXI4-Lite slave.
// Assumes CONNECT_CHANGE pulses come from logic on CLK; OVERCURRENT is a pin.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Write one clears remote wake enable
// - Overcurrent indicator change sets change flag
// - Write one clears change flag, zero ignored
// - Local power change position reads zero
// - Global mode set power: all ports on
// - Per-port mode set: unmasked ports only
// - Connect change wakes only when enabled
// - Wake moves suspended to resume, flags
// - Write one sets remote wake enable
// - Indicator follows overcurrent in global reporting
// - Per-port overcurrent reporting: indicator reads zero
// - Local power status position reads zero
// - Global mode clear power: all ports off
// - Per-port mode clear: unmasked ports only
// - Masked ports ignore global power commands in per-port mode
module root_hub_global_status
    import rh_status_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic OVERCURRENT,
    input wire logic [NPORTS-1:0] CONNECT_CHANGE,
    output logic [NPORTS-1:0] PORT_POWER,
    output logic [1:0] BUS_STATE,
    output logic IRQ
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [ADDR_W-1:0] rd_addr;
        logic [ADDR_W-1:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [2:0] sync;
        logic oc_st;
        logic global_overcurrent_flag;
        logic overcurrent_change_flag;
        logic rwe;
        logic psm;
        logic ppoc;
        logic [NPORTS-1:0] mask;
        logic [NPORTS-1:0] pp;
        bus_state_t state;
        logic [1:0] istat;
        logic [1:0] imask;
        logic irq;
    } state_t;

    state_t s;
    state_t n;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] wd;
    logic [31:0] rd_val;
    logic rd_ok;

    // ************************************************************
    // Bus side
    // ************************************************************
    // Readies are registered and stay low while a response is pending, which keeps
    // combinational paths from the bus inputs out of the handshake
    assign wr_fire = s.aw_got && s.w_got && !s.bvalid;
    assign rd_fire = ARVALID && s.arready;
    assign wd = s.w_data & {{8{s.w_strb[3]}}, {8{s.w_strb[2]}},
                            {8{s.w_strb[1]}}, {8{s.w_strb[0]}}};

    always_comb begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        unique case (ARADDR)
            OFF_PWR_MASK: rd_val[B_MASK_LO +: NPORTS] = s.mask;
            OFF_HUB_STATUS: begin
                rd_val[B_OC_CHANGE] = s.overcurrent_change_flag;
                rd_val[B_WAKE] = s.rwe;
                rd_val[B_OC] = s.global_overcurrent_flag;
            end
            OFF_PWR_CTRL: rd_val[B_PP_SET_LO +: NPORTS] = s.pp;
            OFF_HUB_CTRL: begin
                rd_val[B_PER_PORT_PWR] = s.psm;
                rd_val[B_PER_PORT_OC] = s.ppoc;
                rd_val[B_STATE_LO +: 2] = s.state;
            end
            OFF_INT_STATUS: rd_val[1:0] = s.istat;
            OFF_INT_MASK: rd_val[1:0] = s.imask;
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb begin
        logic [NPORTS-1:0] glob;
        logic [1:0] iset;
        logic [1:0] iclr;
        logic wake;
        glob = '0;
        iset = 2'h0;
        iclr = 2'h0;
        wake = 1'b0;
        n = s;

        // Address and data are taken in either order
        if (AWVALID && s.awready) begin
            n.aw_got = 1'b1;
            n.aw_addr = AWADDR;
        end
        if (WVALID && s.wready) begin
            n.w_got = 1'b1;
            n.w_data = WDATA;
            n.w_strb = WSTRB;
        end
        if (wr_fire) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
        end
        if (s.bvalid && BREADY) begin
            n.bvalid = 1'b0;
        end

        if (rd_fire) begin
            n.rvalid = 1'b1;
            n.rdata = rd_val;
            n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
            n.rd_addr = ARADDR;
            if (ARADDR == OFF_INT_STATUS) begin
                iclr = s.istat;
            end
        end
        if (s.rvalid && RREADY) begin
            n.rvalid = 1'b0;
        end

        // ********************************************************
        // Overcurrent input
        // ********************************************************
        // Only the second and third stages are compared; the first may be metastable
        n.sync = {s.sync[1:0], OVERCURRENT};
        if (s.sync[1] == s.sync[2]) begin
            n.oc_st = s.sync[2];
        end
        n.global_overcurrent_flag = s.ppoc ? 1'b0 : s.oc_st;

        // ********************************************************
        // Register writes
        // ********************************************************
        if (wr_fire) begin
            unique case (s.aw_addr)
                OFF_PWR_MASK: n.mask = wd[B_MASK_LO +: NPORTS];
                OFF_HUB_STATUS: begin
                    glob = s.psm ? ~s.mask : '1;
                    if (wd[B_SET_PWR]) begin
                        n.pp = s.pp | glob;
                    end
                    // Clear follows set, so a write with both bits leaves power off
                    // Clear global power
                    if (wd[B_CLR_PWR]) begin
                        n.pp = n.pp & ~glob;
                    end
                    if (wd[B_OC_CHANGE]) begin
                        n.overcurrent_change_flag = 1'b0;
                    end
                    if (wd[B_WAKE]) begin
                        n.rwe = 1'b1;
                    end
                    // Clear follows set, so both bits in one write leave wake off
                    // Clear wake enable
                    if (wd[B_CLR_WAKE]) begin
                        n.rwe = 1'b0;
                    end
                end
                // Per-port commands ignore mask and mode
                OFF_PWR_CTRL: begin
                    n.pp = (s.pp | wd[B_PP_SET_LO +: NPORTS]) & ~wd[B_PP_CLR_LO +: NPORTS];
                end
                OFF_HUB_CTRL: begin
                    n.psm = wd[B_PER_PORT_PWR];
                    n.ppoc = wd[B_PER_PORT_OC];
                end
                OFF_INT_MASK: n.imask = wd[1:0];
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Change flag set wins over clear
        if (n.global_overcurrent_flag != s.global_overcurrent_flag) begin
            n.overcurrent_change_flag = 1'b1;
            iset[I_OC] = 1'b1;
        end

        // ********************************************************
        // Bus state
        // ********************************************************
        // Connect change wakes only if enabled
        wake = s.rwe && (|CONNECT_CHANGE);
        unique case (s.state)
            bus_operational: begin
                if (wr_fire && s.aw_addr == OFF_HUB_CTRL && wd[B_SUSPEND_CMD]) begin
                    n.state = bus_suspended_state;
                end
            end
            bus_suspended_state: begin
                if (wake) begin
                    n.state = bus_resuming_state;
                    iset[I_RESUME] = 1'b1;
                end else if (wr_fire && s.aw_addr == OFF_HUB_CTRL && wd[B_OPER_CMD]) begin
                    n.state = bus_operational;
                end
            end
            // A suspend command is ignored here; only operational leaves this state
            bus_resuming_state: begin
                if (wr_fire && s.aw_addr == OFF_HUB_CTRL && wd[B_OPER_CMD]) begin
                    n.state = bus_operational;
                end
            end
            default: n.state = bus_operational;
        endcase

        // Read clear loses to a new event in the same cycle
        n.istat = (s.istat & ~iclr) | iset;
        n.irq = |(n.istat & n.imask);

        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s <= '{state: bus_operational, bresp: RESP_OKAY, rresp: RESP_OKAY,
                   sync: RST_SYNC, mask: RST_PORTS, pp: RST_PORTS,
                   istat: RST_INT, imask: RST_INT, default: '0};
        end else begin
            s <= n;
        end
    end

    assign AWREADY = s.awready;
    assign WREADY = s.wready;
    assign BVALID = s.bvalid;
    assign BRESP = s.bresp;
    assign ARREADY = s.arready;
    assign RVALID = s.rvalid;
    assign RDATA = s.rdata;
    assign RRESP = s.rresp;
    assign PORT_POWER = s.pp;
    assign BUS_STATE = s.state;
    assign IRQ = s.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // A status-word write taking effect this cycle
    logic st_wr;
    assign st_wr = wr_fire && s.aw_addr == OFF_HUB_STATUS;

    sequence suspended_wake;
        s.state == bus_suspended_state && s.rwe && (|CONNECT_CHANGE);
    endsequence
    sequence resume_flagged;
        s.state == bus_resuming_state && s.istat[I_RESUME] && (IRQ || !s.imask[I_RESUME]);
    endsequence

    wake_clear_a: assert property (st_wr && wd[B_CLR_WAKE] |=> !s.rwe)
        else $error("wake enable not cleared");
    oc_change_a: assert property (s.global_overcurrent_flag != $past(s.global_overcurrent_flag) |-> s.overcurrent_change_flag)
        else $error("overcurrent change not flagged");
    change_hold_a: assert property (s.overcurrent_change_flag && !(st_wr && wd[B_OC_CHANGE]) |=> s.overcurrent_change_flag)
        else $error("change flag lost without write one");
    local_zero_a: assert property (
        s.rvalid && s.rd_addr == OFF_HUB_STATUS |-> !s.rdata[B_SET_PWR] && !s.rdata[B_CLR_PWR])
        else $error("local power bits read nonzero");
    glob_set_a: assert property (st_wr && !s.psm && wd[B_SET_PWR] && !wd[B_CLR_PWR]
        |=> s.pp == '1) else $error("global set missed a port");
    port_set_a: assert property (st_wr && s.psm && wd[B_SET_PWR] && !wd[B_CLR_PWR]
        |=> (s.pp & ~s.mask) == ~s.mask && (s.pp & s.mask) == ($past(s.pp) & s.mask))
        else $error("per-port set wrong");
    no_wake_a: assert property (s.state == bus_suspended_state && !s.rwe
        |=> s.state != bus_resuming_state) else $error("wake while disabled");
    wake_resume_a: assert property (suspended_wake |=> resume_flagged)
        else $error("wake did not resume");
    wake_set_a: assert property (st_wr && wd[B_WAKE] && !wd[B_CLR_WAKE] |=> s.rwe)
        else $error("wake enable not set");
    oc_follow_a: assert property (!s.ppoc && $stable(s.ppoc) |=> s.global_overcurrent_flag == $past(s.oc_st))
        else $error("indicator does not follow input");
    oc_zero_a: assert property (s.ppoc |=> !s.global_overcurrent_flag)
        else $error("indicator set in per-port mode");
    port_clr_a: assert property (st_wr && s.psm && wd[B_CLR_PWR]
        |=> (s.pp & ~s.mask) == '0 && (s.pp & s.mask) == ($past(s.pp) & s.mask))
        else $error("per-port clear wrong");
    glob_clr_a: assert property (st_wr && !s.psm && wd[B_CLR_PWR] |=> s.pp == '0)
        else $error("global clear missed a port");
    mask_keep_a: assert property (st_wr && s.psm
        |=> (s.pp & s.mask) == ($past(s.pp) & s.mask))
        else $error("masked port changed by a global command");
    set_wins_a: assert property (st_wr && wd[B_OC_CHANGE] && n.global_overcurrent_flag != s.global_overcurrent_flag
        |=> s.overcurrent_change_flag) else $error("change flag clear beat a new change");
endmodule
`default_nettype wire

// file: dv/tb_root_hub_global_status.sv
// Self-checking bench for the root hub global status register bank.
// Assumes the AXI4-Lite slave, the port map and the register offsets in rh_status_pkg.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("BAD %s expected %0h seen %0h", nm, e, g); \
    end \
end
module tb_root_hub_global_status;
    import rh_status_pkg::*;
    logic CLK = 1'b0, RST = 1'b1;
    logic [ADDR_W-1:0] AWADDR = '0, ARADDR = '0;
    logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0, OVERCURRENT = 1'b0;
    logic [31:0] WDATA = '0;
    logic [3:0] WSTRB = 4'hF, wstrb_q = 4'hF;
    logic [NPORTS-1:0] CONNECT_CHANGE = '0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
    logic [1:0] BRESP, RRESP, BUS_STATE;
    logic [31:0] RDATA, rd_q;
    logic [1:0] resp_q;
    logic [NPORTS-1:0] PORT_POWER;
    int err_total = 0, num_checks = 0;

    // Ready lines held high: the bench always accepts answers at once
    root_hub_global_status i_root_hub_global_status (
        .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(1'b1), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(1'b1), .OVERCURRENT(OVERCURRENT),
        .CONNECT_CHANGE(CONNECT_CHANGE), .PORT_POWER(PORT_POWER),
        .BUS_STATE(BUS_STATE), .IRQ(IRQ));

    always #2.5 CLK = ~CLK;

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic timed_out();
        err_total++;
        $display("BAD handshake expected done seen hang");
        end_of_test();
    endtask

    // ************************************************************
    // Bus tasks: entered and left just after a rising edge
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= wstrb_q;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            if (n > 40) timed_out();
        end while (!BVALID);
        resp_q = BRESP;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            if (n > 40) timed_out();
        end while (!RVALID);
        rd_q = RDATA;
        resp_q = RRESP;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd(a);
        `CHK(nm, e, rd_q)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask

    task automatic wake_pulse();
        CONNECT_CHANGE <= 4'h2;
        tick(1);
        CONNECT_CHANGE <= 4'h0;
        tick(3);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        tick(3);
        RST <= 1'b0;
        tick(1);
        rchk(OFF_HUB_STATUS, 32'h0000_0000, "status reset");
        rd(8'h20);
        `CHK("unmapped resp", RESP_SLVERR, resp_q)
        wr(8'h20, 32'h0000_0000);
        `CHK("unmapped write resp", RESP_SLVERR, resp_q)
        wr(OFF_INT_MASK, 32'h0000_0003);
        `CHK("write resp", RESP_OKAY, resp_q)
        rchk(OFF_INT_MASK, 32'h0000_0003, "int mask read");
        // Reserved bits written zero
        // Wake enable set and clear commands
        wr(OFF_HUB_STATUS, 32'h0000_8000);
        rchk(OFF_HUB_STATUS, 32'h0000_8000, "wake set");
        wr(OFF_HUB_STATUS, 32'h0000_0000);
        rchk(OFF_HUB_STATUS, 32'h0000_8000, "wake zero write");
        wr(OFF_HUB_STATUS, 32'h8000_0000);
        rchk(OFF_HUB_STATUS, 32'h0000_0000, "wake clear");
        // Strobe off for the byte holding the wake enable set bit
        wstrb_q = 4'hD;
        wr(OFF_HUB_STATUS, 32'h0000_8000);
        wstrb_q = 4'hF;
        rchk(OFF_HUB_STATUS, 32'h0000_0000, "strobed write");
        // Global power switching mode
        wr(OFF_HUB_STATUS, 32'h0001_0000);
        tick(1);
        `CHK("global set", 4'hF, PORT_POWER)
        rchk(OFF_HUB_STATUS, 32'h0000_0000, "power bits read");
        wr(OFF_HUB_STATUS, 32'h0000_0000);
        tick(1);
        `CHK("zero write power", 4'hF, PORT_POWER)
        wr(OFF_HUB_STATUS, 32'h0000_0001);
        tick(1);
        `CHK("global clear", 4'h0, PORT_POWER)
        // Per-port mode, ports 0 and 2 masked
        wr(OFF_PWR_MASK, 32'h000A_0000);
        wr(OFF_HUB_CTRL, 32'h0000_0001);
        wr(OFF_PWR_CTRL, 32'h0000_0002);
        wr(OFF_HUB_STATUS, 32'h0001_0000);
        tick(1);
        `CHK("masked set", 4'hB, PORT_POWER)
        wr(OFF_HUB_STATUS, 32'h0000_0001);
        tick(1);
        `CHK("masked clear", 4'h1, PORT_POWER)
        rchk(OFF_PWR_MASK, 32'h000A_0000, "mask read");
        rchk(OFF_PWR_CTRL, 32'h0000_0002, "port power read");
        // Overcurrent with global reporting
        // Clear meets the change
        OVERCURRENT <= 1'b1;
        tick(3);
        wr(OFF_HUB_STATUS, 32'h0002_0000);
        rchk(OFF_HUB_STATUS, 32'h0002_0002, "oc raised");
        `CHK("irq oc", 1'b1, IRQ)
        wr(OFF_HUB_STATUS, 32'h0000_0000);
        rchk(OFF_HUB_STATUS, 32'h0002_0002, "change zero write");
        wr(OFF_HUB_STATUS, 32'h0002_0000);
        rchk(OFF_HUB_STATUS, 32'h0000_0002, "change cleared");
        rchk(OFF_INT_STATUS, 32'h0000_0001, "int oc");
        rchk(OFF_INT_STATUS, 32'h0000_0000, "int read clear");
        tick(2);
        `CHK("irq low", 1'b0, IRQ)
        // Per-port overcurrent reporting forces the indicator low
        wr(OFF_HUB_CTRL, 32'h0000_0003);
        OVERCURRENT <= 1'b0;
        tick(8);
        rchk(OFF_HUB_STATUS, 32'h0002_0000, "oc per port");
        wr(OFF_HUB_STATUS, 32'h0002_0000);
        rd(OFF_INT_STATUS);
        // Connect change ignored while wake is disabled
        wr(OFF_HUB_CTRL, 32'h0000_0007);
        tick(1);
        `CHK("suspended", 2'h1, BUS_STATE)
        rchk(OFF_HUB_CTRL, 32'h0000_0013, "state read");
        wake_pulse();
        `CHK("no wake", 2'h1, BUS_STATE)
        rchk(OFF_INT_STATUS, 32'h0000_0000, "no resume int");
        wr(OFF_HUB_STATUS, 32'h0000_8000);
        wake_pulse();
        `CHK("wake resume", 2'h3, BUS_STATE)
        `CHK("irq resume", 1'b1, IRQ)
        rchk(OFF_INT_STATUS, 32'h0000_0002, "resume int");
        wr(OFF_HUB_CTRL, 32'h0000_000B);
        tick(1);
        `CHK("operational", 2'h0, BUS_STATE)
        rchk(OFF_HUB_CTRL, 32'h0000_0003, "control read");
        wr(OFF_PWR_CTRL, 32'h0000_0200);
        tick(1);
        `CHK("port clear", 4'h0, PORT_POWER)
        end_of_test();
    end
endmodule
`default_nettype wire
